// file: rtl/sar_adc_control.sv
// Top of the SAR converter control: AXI4-Lite registers, start flag, result and request
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module sar_adc_control
  import sar_adc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_trigger_pin,
  input wire logic comp_in,
  output sar_drive_type ana_drive,
  output logic conv_end_irq
);

  // Bus slave state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_full_ff, w_full_ff, wlane_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;

  // Block state
  mode_type mode_ff;
  logic start_flag_ff;
  logic conv_end_irq_flag_ff, conv_end_irq_enable_ff, trigger_edge_select_ff;
  logic irq_out_ff;
  logic [7:0] result_ff;
  chan_type chan_ff;

  // Handshakes and write decode
  logic aw_hs, w_hs, ar_hs, b_hs, r_hs, wr_do, wr_hit;
  logic nxt_aw_full, nxt_w_full;
  reg_type wr_sel, rd_sel;
  logic wr_mode, wr_start, wr_irq, wr_one, wr_zero;
  logic [7:0] rd_byte;

  // Start and interrupt control
  logic trig_pulse, trig_go, set_ev, launch, halt;
  logic seq_done, seq_sample;
  logic [7:0] seq_trial;
  logic nxt_start_flag, nxt_irq_flag, irq_clr;

  assign aw_hs = awvalid & awready_ff;
  assign w_hs = wvalid & wready_ff;
  assign ar_hs = arvalid & arready_ff;
  assign b_hs = bvalid_ff & bready;
  assign r_hs = rvalid_ff & rready;

  // Address and data are taken in either order; the write lands once both are held
  assign wr_do = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign nxt_aw_full = aw_hs | (aw_full_ff & ~wr_do);
  assign nxt_w_full = w_hs | (w_full_ff & ~wr_do);
  assign wr_sel = reg_decode(awaddr_ff);
  assign wr_hit = wr_do & wlane_ff;
  assign wr_mode = wr_hit & (wr_sel == REG_MODE);
  assign wr_start = wr_hit & (wr_sel == REG_START);
  assign wr_irq = wr_hit & (wr_sel == REG_IRQ);
  assign wr_one = wr_start & wdata_ff[START_FLAG_BIT];
  assign wr_zero = wr_start & ~wdata_ff[START_FLAG_BIT];

  // Read mux; reserved bits read as one where the register defines them so
  assign rd_sel = reg_decode(araddr);
  assign rd_byte = (rd_sel == REG_MODE) ? mode_ff :
                   (rd_sel == REG_RESULT) ? result_ff :
                   (rd_sel == REG_START) ? {start_flag_ff, START_RSV} :
                   (rd_sel == REG_IRQ) ? {5'h00, trigger_edge_select_ff,
                                          conv_end_irq_enable_ff, conv_end_irq_flag_ff} :
                   8'h00;

  // Trigger only counts while enabled; a set beats a clear in the same cycle
  assign trig_go = trig_pulse & mode_ff.trig_en;
  assign set_ev = wr_one | trig_go;
  assign launch = set_ev & (~start_flag_ff | seq_done);
  assign halt = wr_zero & ~set_ev;
  assign nxt_start_flag = set_ev | (start_flag_ff & ~seq_done & ~wr_zero);

  // Completion flag: write one to clear, completion wins over a clear
  assign irq_clr = wr_irq & wdata_ff[IRQ_FLAG_BIT];
  assign nxt_irq_flag = seq_done | (conv_end_irq_flag_ff & ~irq_clr);

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign conv_end_irq = irq_out_ff;
  assign ana_drive = '{sample: seq_sample, chan_valid: chan_ff.valid,
                       chan: chan_ff.idx, trial: seq_trial};

  trigger_edge_sync trig_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ext_trigger_pin),
    .rising(trigger_edge_select_ff),
    .edge_pulse(trig_pulse)
  );

  sar_sequencer seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(launch),
    .stop(halt),
    .fast(mode_ff.speed),
    .comp_in(comp_in),
    .done(seq_done),
    .sample(seq_sample),
    .trial(seq_trial)
  );

  // Write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= ~nxt_aw_full;
      wready_ff <= ~nxt_w_full;
      if (aw_hs)
        awaddr_ff <= awaddr;
      if (w_hs)
      begin
        wdata_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
      end
      if (wr_do)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (b_hs)
        bvalid_ff <= 1'b0;
    end
  end

  // Read channel: one read outstanding, data registered at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (r_hs)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // Mode, start flag and interrupt control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_ff <= MODE_RESET;
      start_flag_ff <= 1'b0;
      conv_end_irq_flag_ff <= 1'b0;
      conv_end_irq_enable_ff <= 1'b0;
      trigger_edge_select_ff <= 1'b0;
      irq_out_ff <= 1'b0;
      chan_ff <= '0;
    end
    else
    begin
      if (wr_mode)
        mode_ff <= '{speed: wdata_ff[7], trig_en: wdata_ff[6],
                     rsv: MODE_RESET[5:4], chan: wdata_ff[3:0]};
      if (wr_irq)
      begin
        conv_end_irq_enable_ff <= wdata_ff[IRQ_EN_BIT];
        trigger_edge_select_ff <= wdata_ff[IRQ_EDGE_BIT];
      end
      start_flag_ff <= nxt_start_flag;
      conv_end_irq_flag_ff <= nxt_irq_flag;
      irq_out_ff <= conv_end_irq_flag_ff & conv_end_irq_enable_ff;
      chan_ff <= chan_decode(mode_ff.chan);
    end
  end

  // Result has no reset on purpose: it survives a system reset unchanged
  always_ff @(posedge aclk)
  begin
    if (seq_done)
      result_ff <= seq_trial;
  end

  // Checking helpers: cycles since launch and the speed in force at launch
  logic [5:0] run_cnt_ff;
  logic run_fast_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_cnt_ff <= 6'h00;
      run_fast_ff <= 1'b0;
    end
    else if (launch)
    begin
      run_cnt_ff <= 6'h00;
      run_fast_ff <= mode_ff.speed;
    end
    else if (start_flag_ff)
      run_cnt_ff <= run_cnt_ff + 6'h01;
  end

  mode_reset_a: assert property (@(posedge aclk)
    !aresetn |=> (mode_ff == MODE_RESET) && !start_flag_ff)
    else $error("mode register or start flag wrong after reset");

  mode_rsv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ff[5:4] == 2'b11)
    else $error("mode reserved bits not one");

  start_rsv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && rd_sel == REG_START) |=> rdata_ff[6:0] == START_RSV)
    else $error("start register reserved bits not one");

  conv_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_done && start_flag_ff) |->
      run_cnt_ff == 6'((run_fast_ff ? CONV_LEN_FAST : CONV_LEN_SLOW) - 1))
    else $error("conversion length does not match speed select");

  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_done && !set_ev) |=> !start_flag_ff && (result_ff == $past(seq_trial)))
    else $error("start flag not cleared with result store");

  result_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !seq_done |=> $stable(result_ff))
    else $error("result changed without a completion");

  irq_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_done |=> conv_end_irq_flag_ff ##1 (conv_end_irq == conv_end_irq_enable_ff))
    else $error("completion did not raise the gated request");

  trig_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_pulse && !mode_ff.trig_en && !wr_one && !start_flag_ff) |=> !start_flag_ff)
    else $error("disabled trigger started a conversion");

  trig_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_go && !start_flag_ff) |=> start_flag_ff ##1 ana_drive.sample)
    else $error("enabled trigger did not start a conversion");

  stop_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    halt |=> !start_flag_ff && !ana_drive.sample && !seq_done)
    else $error("write of zero did not stop the conversion");

  start_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_one && !start_flag_ff) |=> start_flag_ff && ana_drive.trial == TRIAL_INIT)
    else $error("write of one did not start a conversion");

  chan_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_ff.chan == 4'h5) |=> chan_ff.valid && chan_ff.idx == 3'h1)
    else $error("channel code 0101 did not select input 1");

  // Bus answers stand until the master takes them
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_ff && !bready) |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped early");

  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_ff && !rready) |=> rvalid_ff && $stable(rdata_ff))
    else $error("read data dropped early");

  // Start flag tracks the conversion: only done or a stop may clear it
  busy_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_flag_ff && !seq_done && !wr_zero) |=> start_flag_ff)
    else $error("start flag dropped mid conversion");

  idle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!start_flag_ff && !set_ev) |=> !start_flag_ff && !ana_drive.sample)
    else $error("converter left idle without a start");

  done_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_done |-> start_flag_ff)
    else $error("completion with start flag low");

  busy_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_flag_ff |-> run_cnt_ff < 6'(CONV_LEN_SLOW))
    else $error("conversion ran past the slow length");

  launch_init_a: assert property (@(posedge aclk) disable iff (!aresetn)
    launch |=> ana_drive.sample && ana_drive.trial == TRIAL_INIT)
    else $error("conversion did not open with sample and midpoint");

  // Completion flag survives until cleared, request stays low while masked
  irq_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_end_irq_flag_ff && !irq_clr) |=> conv_end_irq_flag_ff)
    else $error("completion flag lost without a clear");

  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !conv_end_irq_enable_ff |=> !conv_end_irq)
    else $error("request raised while disabled");

  // Register contents as seen from the bus
  result_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && rd_sel == REG_RESULT) |=> rdata_ff == {24'h00_0000, $past(result_ff)})
    else $error("result read returned the wrong value");

  mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mode |=> mode_ff == ($past(wdata_ff) | 8'h30))
    else $error("mode write stored the wrong value");

  chan_unused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_ff.chan[3:2] == 2'b00 || mode_ff.chan[3:2] == 2'b11) |=> !chan_ff.valid)
    else $error("unused channel code selected an input");

  chan_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_ff.chan[3:2] == 2'b01 && !wr_mode) |=>
      chan_ff.valid && chan_ff.idx == {1'b0, mode_ff.chan[1:0]})
    else $error("channel code 01xx decoded wrongly");

  chan_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_ff.chan[3:2] == 2'b10 && !wr_mode) |=>
      chan_ff.valid && chan_ff.idx == {1'b1, mode_ff.chan[1:0]})
    else $error("channel code 10xx decoded wrongly");

endmodule

// file: rtl/sar_adc_pkg.sv
// Constants, field layouts and carrier types for the SAR converter control block
// What this block does
// - Convert the selected input by successive approximation into an 8-bit value.
// - Store the 8-bit result at completion and hold it until the next start.
// - Result register is readable any time; its contents mid-conversion are undefined.
// - Reset never clears or alters the result register; power-up value is undefined.
// - Mode register resets to 30h: speed, trigger enable and channel zero.
// - Speed bit 0 gives 62 clock periods per conversion, bit 1 gives 31.
// - Trigger enable 0 ignores trigger pin edges; 1 lets an edge start conversion.
// - With trigger enabled, the selected pin edge sets the start flag and starts.
// - Mode bits 5 and 4 always read 1 and ignore writes.
// - Start register bits 6..0 read 1 and ignore writes; bit 7 resets 0.
// - Channel code 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx reserved.
// - Writing 1 to the start flag starts a conversion; writing 0 stops it.
// - Start flag reads 1 during conversion and clears as the result is stored.
// - Each completion sets the end flag; a request goes out only when enabled.
// - After completion the converter idles until the flag is set again.
package sar_adc_pkg;

  // Register map, byte addresses on the AXI4-Lite port
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_RESULT = 5'h04;
  localparam logic [4:0] OFF_START = 5'h08;
  localparam logic [4:0] OFF_IRQ = 5'h0C;

  // Field positions
  localparam int START_FLAG_BIT = 7;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int IRQ_EDGE_BIT = 2;

  // Reset and fixed read values
  localparam logic [7:0] MODE_RESET = 8'h30;
  localparam logic [6:0] START_RSV = 7'h7F;
  localparam logic [7:0] TRIAL_INIT = 8'h80;

  // Conversion timing in clock cycles: sample phase, then eight bit steps, then store
  localparam int CONV_LEN_SLOW = 62;
  localparam int CONV_LEN_FAST = 31;
  localparam logic [3:0] SAMPLE_SLOW = 4'hD;
  localparam logic [3:0] SAMPLE_FAST = 4'h6;
  localparam logic [3:0] STEP_SLOW = 4'h6;
  localparam logic [3:0] STEP_FAST = 4'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic speed;
    logic trig_en;
    logic [1:0] rsv;
    logic [3:0] chan;
  } mode_type;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
  } chan_type;

  // Drive toward the analog core
  typedef struct packed {
    logic sample;
    logic chan_valid;
    logic [2:0] chan;
    logic [7:0] trial;
  } sar_drive_type;

  typedef enum logic [2:0] {REG_MODE, REG_RESULT, REG_START, REG_IRQ, REG_NONE} reg_type;

  // Address decode shared by the read and write paths
  function automatic reg_type reg_decode(input logic [ADDR_W-1:0] addr);
    reg_type sel;
    sel = REG_NONE;
    if (addr == OFF_MODE)
      sel = REG_MODE;
    else if (addr == OFF_RESULT)
      sel = REG_RESULT;
    else if (addr == OFF_START)
      sel = REG_START;
    else if (addr == OFF_IRQ)
      sel = REG_IRQ;
    return sel;
  endfunction

  // Channel code to analog input index; reserved codes select nothing
  function automatic chan_type chan_decode(input logic [3:0] code);
    chan_type c;
    c.valid = (code[3:2] == 2'b01) || (code[3:2] == 2'b10);
    c.idx = {code[3], code[1:0]};
    return c;
  endfunction

endpackage

// file: rtl/trigger_edge_sync.sv
// Trigger pin synchroniser and single-pulse edge detector
`timescale 1ns/100ps
module trigger_edge_sync
  import sar_adc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  input wire logic rising,
  output logic edge_pulse
);

  logic sync1_ff, sync2_ff, prev_ff, pulse_ff;
  logic nxt_pulse;

  // Only the second stage and its delayed copy feed the detector
  assign nxt_pulse = rising ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);
  assign edge_pulse = pulse_ff;

  // Two-stage synchroniser, then one pulse per detected edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      pulse_ff <= nxt_pulse;
    end
  end

  one_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_pulse |=> !edge_pulse)
    else $error("trigger edge gave more than one start pulse");

endmodule

// file: rtl/sar_sequencer.sv
// Successive-approximation sequencer: sample phase then eight bit decisions
`timescale 1ns/100ps
module sar_sequencer
  import sar_adc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic stop,
  input wire logic fast,
  input wire logic comp_in,
  output logic done,
  output logic sample,
  output logic [7:0] trial
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_APPROX} seq_state_type;

  seq_state_type state_ff;
  logic [3:0] phase_ff;
  logic [2:0] bit_ff;
  logic fast_ff, done_ff, sample_ff;
  logic [7:0] trial_ff;
  logic [3:0] phase_last;
  logic phase_end;
  logic [7:0] bit_mask, decided;

  // Speed is latched at start so a stray mode write cannot bend a running conversion
  assign phase_last = (state_ff == SEQ_SAMPLE) ?
                      (fast_ff ? SAMPLE_FAST - 4'h1 : SAMPLE_SLOW - 4'h1) :
                      (fast_ff ? STEP_FAST - 4'h1 : STEP_SLOW - 4'h1);
  assign phase_end = (phase_ff == phase_last);
  assign bit_mask = 8'h01 << bit_ff;
  // Comparator high means input at or above the trial: keep the bit
  assign decided = comp_in ? trial_ff : (trial_ff & ~bit_mask);
  assign done = done_ff;
  assign sample = sample_ff;
  assign trial = trial_ff;

  // Sequencing; start takes priority so a restart in the done cycle is not lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= SEQ_IDLE;
      phase_ff <= 4'h0;
      bit_ff <= 3'h0;
      fast_ff <= 1'b0;
      done_ff <= 1'b0;
      sample_ff <= 1'b0;
      trial_ff <= 8'h00;
    end
    else
    begin
      done_ff <= 1'b0;
      if (start)
      begin
        state_ff <= SEQ_SAMPLE;
        phase_ff <= 4'h0;
        bit_ff <= 3'h7;
        fast_ff <= fast;
        sample_ff <= 1'b1;
        trial_ff <= TRIAL_INIT;
      end
      else if (stop)
      begin
        state_ff <= SEQ_IDLE;
        sample_ff <= 1'b0;
      end
      else
      begin
        unique case (state_ff)
          SEQ_IDLE:
          begin
            phase_ff <= 4'h0;
          end
          SEQ_SAMPLE:
          begin
            phase_ff <= phase_end ? 4'h0 : phase_ff + 4'h1;
            if (phase_end)
            begin
              state_ff <= SEQ_APPROX;
              sample_ff <= 1'b0;
            end
          end
          SEQ_APPROX:
          begin
            phase_ff <= phase_end ? 4'h0 : phase_ff + 4'h1;
            if (phase_end)
            begin
              trial_ff <= decided | (bit_mask >> 1);
              bit_ff <= bit_ff - 3'h1;
              if (bit_ff == 3'h0)
              begin
                state_ff <= SEQ_IDLE;
                done_ff <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// file: verif/adc_core_model.sv
// Behavioural analog core: comparator against fixed input levels, no sample-and-hold
`timescale 1ns/100ps
module adc_core_model
  import sar_adc_pkg::*;
#(
  parameter logic [63:0] LEVELS = 64'h0
)
(
  input wire sar_drive_type ana_drive,
  output logic comp_in
);
  // Comparator answers at once; with no channel selected the input reads as ground
  assign comp_in = ana_drive.chan_valid && (LEVELS[ana_drive.chan*8 +: 8] >= ana_drive.trial);
endmodule

// file: verif/sar_adc_control_bench.sv
// Self-checking bench for the SAR converter control block over AXI4-Lite
`timescale 1ns/100ps
module sar_adc_control_bench
  import sar_adc_pkg::*;
;
  // One distinct level per input so a wrong channel mux shows in the result
  localparam logic [63:0] LEVELS = 64'hE7C33C965A21A50F;
  localparam int LIMIT = 6000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic ext_trigger_pin = 1'b0;
  logic comp_in;
  logic conv_end_irq;
  sar_drive_type ana_drive;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;

  sar_adc_control u_sar_adc_control (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_trigger_pin(ext_trigger_pin), .comp_in(comp_in),
    .ana_drive(ana_drive), .conv_end_irq(conv_end_irq));

  adc_core_model #(.LEVELS(LEVELS)) u_adc_core_model (.ana_drive(ana_drive), .comp_in(comp_in));

  // Clock at 125 MHz
  always #4 aclk = ~aclk;

  // Cycle count for latency checks; a hang past the ceiling ends the run as a failure
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: resp got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp)
    begin
      err_total++;
      $display("ERROR at %0t: cycles got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken; t0 marks the answer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    t0 = cyc;
    bready <= 1'b0;
  endtask

  // Read: rready held until the data is sampled
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    rd(a);
    chk_data(rd_val, {24'h0, exp});
    chk_resp(rd_resp, RESP_OKAY);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic pin_set(input logic v);
    @(posedge aclk);
    ext_trigger_pin <= v;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Full conversion with the request enabled: latency, result, flag and request
  task automatic conv(input logic [7:0] mode, input int len, input logic [7:0] exp);
    // Mode changes only while idle; the model core has no settling limit
    wr(OFF_MODE, mode);
    wr(OFF_START, 8'h80);
    rd_chk(OFF_START, 8'hFF);
    while (conv_end_irq !== 1'b1)
      @(posedge aclk);
    chk_cnt(cyc - t0, len + 1);
    rd_chk(OFF_RESULT, exp);
    rd_chk(OFF_START, 8'h7F);
    rd_chk(OFF_IRQ, 8'h03);
    wr(OFF_IRQ, 8'h03);
    rd_chk(OFF_IRQ, 8'h02);
  endtask

  // Main sequence
  initial
  begin
    do_reset();
    rd_chk(OFF_MODE, MODE_RESET);
    rd_chk(OFF_START, 8'h7F);
    wr(OFF_MODE, 8'hFF);
    rd_chk(OFF_MODE, 8'hFF);
    // Every channel code: reserved bits stay 1, decode shows on the analog drive
    for (int c = 0; c < 16; c++)
    begin
      wr(OFF_MODE, {4'h0, c[3:0]});
      rd_chk(OFF_MODE, {4'h3, c[3:0]});
      chk_data({28'h0, ana_drive.chan_valid, ana_drive.chan}, {28'h0, c[3] ^ c[2], c[3], c[1:0]});
    end
    wr(OFF_START, 8'h7F);
    rd_chk(OFF_START, 8'h7F);
    wr(5'h10, 8'hFF);
    chk_resp(wr_resp, RESP_SLVERR);
    rd(5'h14);
    chk_data(rd_val, 32'h0);
    chk_resp(rd_resp, RESP_SLVERR);
    // Slow then fast conversions back to back, request enabled
    wr(OFF_IRQ, 8'h02);
    conv(8'h05, CONV_LEN_SLOW, LEVELS[15:8]);
    conv(8'h8A, CONV_LEN_FAST, LEVELS[55:48]);
    // Request masked: flag still set, output stays low
    wr(OFF_IRQ, 8'h00);
    wr(OFF_MODE, 8'h84);
    wr(OFF_START, 8'h80);
    wait_cyc(40);
    chk_data({31'h0, conv_end_irq}, 32'h0);
    rd_chk(OFF_IRQ, 8'h01);
    rd_chk(OFF_RESULT, LEVELS[7:0]);
    wr(OFF_IRQ, 8'h01);
    // Stop mid-conversion: no result, no end flag
    wr(OFF_MODE, 8'h0B);
    wr(OFF_START, 8'h80);
    wait_cyc(5);
    wr(OFF_START, 8'h00);
    rd_chk(OFF_START, 8'h7F);
    wait_cyc(70);
    rd_chk(OFF_RESULT, LEVELS[7:0]);
    rd_chk(OFF_IRQ, 8'h00);
    // Reset while idle keeps the result but restores the mode
    do_reset();
    rd_chk(OFF_RESULT, LEVELS[7:0]);
    rd_chk(OFF_MODE, MODE_RESET);
    // Byte lane 0 off: the write is answered but changes nothing
    wstrb <= 4'hE;
    wr(OFF_MODE, 8'hC0);
    wstrb <= 4'hF;
    chk_resp(wr_resp, RESP_OKAY);
    rd_chk(OFF_MODE, MODE_RESET);
    // Trigger pin: ignored while disabled, then rising edge selected
    wr(OFF_IRQ, 8'h04);
    wr(OFF_MODE, 8'h85);
    pin_set(1'b1);
    wait_cyc(10);
    rd_chk(OFF_START, 8'h7F);
    pin_set(1'b0);
    wait_cyc(5);
    wr(OFF_MODE, 8'hC5);
    pin_set(1'b1);
    wait_cyc(6);
    rd_chk(OFF_START, 8'hFF);
    wait_cyc(40);
    rd_chk(OFF_RESULT, LEVELS[15:8]);
    rd_chk(OFF_START, 8'h7F);
    pin_set(1'b0);
    wait_cyc(10);
    rd_chk(OFF_START, 8'h7F);
    // Falling edge selected: a rise is ignored, a fall starts
    wr(OFF_IRQ, 8'h00);
    pin_set(1'b1);
    wait_cyc(10);
    rd_chk(OFF_START, 8'h7F);
    pin_set(1'b0);
    wait_cyc(6);
    rd_chk(OFF_START, 8'hFF);
    wait_cyc(40);
    rd_chk(OFF_START, 8'h7F);
    stop_test();
  end
endmodule
